// File: rtl/metering_cfg_pkg.sv
// Constants and types shared by the computation mode configuration block
package metering_cfg_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [17:0] IDX_COMP_MODE   = 18'h0e60e;
  localparam logic [17:0] IDX_NOM_VOLTAGE = 18'h0e610;
  localparam logic [17:0] IDX_STATUS      = 18'h0e611;
  localparam logic [17:0] IDX_RESULT_CNT  = 18'h0e612;

  localparam logic [ADDR_W-1:0] ADDR_COMP_MODE   = {IDX_COMP_MODE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_NOM_VOLTAGE = {IDX_NOM_VOLTAGE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS      = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RESULT_CNT  = {IDX_RESULT_CNT, 2'b00};

  // Field positions of computation_mode_config
  localparam int unsigned F_SEL_ONE_LSB   = 0;
  localparam int unsigned F_SEL_TWO_LSB   = 3;
  localparam int unsigned F_SEL_THREE_LSB = 6;
  localparam int unsigned F_ANGLE_LSB     = 9;
  localparam int unsigned F_NOM_A         = 11;
  localparam int unsigned F_NOM_B         = 12;
  localparam int unsigned F_NOM_C         = 13;

  // Implemented bits and reset values
  localparam logic [15:0] COMP_MODE_MASK  = 16'h3fff;
  localparam logic [15:0] COMP_MODE_RESET = 16'h01ff;
  localparam logic [23:0] NOM_VOLT_RESET  = 24'h000000;

  // Status field positions
  localparam int unsigned S_IGNORE_LSB = 0;
  localparam int unsigned S_ANGLE_LSB  = 4;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    ANG_V_TO_I = 2'b00,
    ANG_V_TO_V = 2'b01,
    ANG_I_TO_I = 2'b10,
    ANG_NONE   = 2'b11
  } angle_mode_e;

endpackage : metering_cfg_pkg

// File: rtl/phase_term_sum.sv
// Sums the per-phase values selected by a three-bit phase mask
`timescale 1ns/1ps
`default_nettype none
module phase_term_sum #(
  parameter int unsigned W = 24
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Selection and inputs
  input  wire logic [2:0]          sel,
  input  wire logic                valid,
  input  wire logic signed [W-1:0] val_a,
  input  wire logic signed [W-1:0] val_b,
  input  wire logic signed [W-1:0] val_c,
  // Result
  output logic signed [W+1:0]      sum
);

  logic signed [W+1:0] sum_q;
  logic signed [W+1:0] sum_d;

  // Unselected phases contribute zero; all three set gives the full sum
  always_comb begin
    sum_d = sum_q;
    if (valid) begin
      sum_d = (sel[0] ? (W+2)'(val_a) : '0)
            + (sel[1] ? (W+2)'(val_b) : '0)
            + (sel[2] ? (W+2)'(val_c) : '0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_q <= '0;
    end else begin
      sum_q <= sum_d;
    end
  end

  assign sum = sum_q;

endmodule : phase_term_sum
`default_nettype wire

// File: rtl/apparent_calc.sv
// Picks measured or nominal rms voltage and forms apparent power
`timescale 1ns/1ps
`default_nettype none
module apparent_calc #(
  parameter int unsigned VW = 24,
  parameter int unsigned IW = 24
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Control
  input  wire logic               nom_en,
  input  wire logic [VW-1:0]      nom_value,
  input  wire logic               valid,
  // Measurements
  input  wire logic [VW-1:0]      vrms,
  input  wire logic [IW-1:0]      irms,
  // Results
  output logic [VW-1:0]           veff,
  output logic [VW+IW-1:0]        apparent
);

  logic [VW-1:0]    veff_q;
  logic [VW-1:0]    veff_d;
  logic [VW+IW-1:0] app_q;
  logic [VW+IW-1:0] app_d;
  logic [VW-1:0]    vsel;

  // Nominal value replaces every rms voltage use, measured input ignored
  always_comb begin
    vsel   = nom_en ? nom_value : vrms;
    veff_d = veff_q;
    app_d  = app_q;
    if (valid) begin
      veff_d = vsel;
      app_d  = (VW+IW)'(vsel) * (VW+IW)'(irms);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      veff_q <= '0;
      app_q  <= '0;
    end else begin
      veff_q <= veff_d;
      app_q  <= app_d;
    end
  end

  assign veff     = veff_q;
  assign apparent = app_q;

endmodule : apparent_calc
`default_nettype wire

// File: rtl/metering_compute_mode_config.sv
// Computation mode configuration register with AHB-Lite access and datapath
//
// Functional notes
// - First pulse output sums phases selected per bit
// - Second pulse output sums its selected phases
// - Third pulse output sums its selected phases
// - Default angle mode measures voltage-to-current angles
// - Angle field selects V-I, V-V, I-I, none
// - Phase A enable low uses measured voltage
// - Phase A enable high substitutes nominal voltage
// - Phase B enable high substitutes nominal voltage
// - Phase C enable selects measured or nominal
`timescale 1ns/1ps
`default_nettype none
module metering_compute_mode_config
  import metering_cfg_pkg::*;
#(
  parameter int unsigned POWER_W = 24,
  parameter int unsigned RMS_W   = 24
) (
  // Clock and reset
  input  wire logic                      MCLK,
  input  wire logic                      RESET_N,
  // AHB-Lite slave
  input  wire logic                      HSEL,
  input  wire logic [ADDR_W-1:0]         HADDR,
  input  wire logic [1:0]                HTRANS,
  input  wire logic                      HWRITE,
  input  wire logic [2:0]                HSIZE,
  input  wire logic [DATA_W-1:0]         HWDATA,
  input  wire logic                      HREADY,
  output logic [DATA_W-1:0]              HRDATA,
  output logic                           HREADYOUT,
  output logic                           HRESP,
  // Per-phase measurements from the signal processor
  input  wire logic                      SAMPLE_VALID,
  input  wire logic signed [POWER_W-1:0] POWER_A,
  input  wire logic signed [POWER_W-1:0] POWER_B,
  input  wire logic signed [POWER_W-1:0] POWER_C,
  input  wire logic [RMS_W-1:0]          VRMS_A,
  input  wire logic [RMS_W-1:0]          VRMS_B,
  input  wire logic [RMS_W-1:0]          VRMS_C,
  input  wire logic [RMS_W-1:0]          IRMS_A,
  input  wire logic [RMS_W-1:0]          IRMS_B,
  input  wire logic [RMS_W-1:0]          IRMS_C,
  // Pulse output feeds
  output logic signed [POWER_W+1:0]      PULSE_OUT_ONE_SUM,
  output logic signed [POWER_W+1:0]      PULSE_OUT_TWO_SUM,
  output logic signed [POWER_W+1:0]      PULSE_OUT_THREE_SUM,
  // Effective rms voltage and apparent power
  output logic [RMS_W-1:0]               VRMS_EFF_A,
  output logic [RMS_W-1:0]               VRMS_EFF_B,
  output logic [RMS_W-1:0]               VRMS_EFF_C,
  output logic [2*RMS_W-1:0]             APPARENT_A,
  output logic [2*RMS_W-1:0]             APPARENT_B,
  output logic [2*RMS_W-1:0]             APPARENT_C,
  output logic                           RESULT_VALID,
  // Angle measurement and voltage input control
  output logic                           ANGLE_V_TO_I_EN,
  output logic                           ANGLE_V_TO_V_EN,
  output logic                           ANGLE_I_TO_I_EN,
  output logic [2:0]                     VOLTAGE_INPUT_IGNORE
);

  // Register address match, shared by read and write decode
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] reg_addr);
    return a == reg_addr;
  endfunction : addr_is

  // Bus state
  logic                  wr_pend_q;
  logic                  wr_pend_d;
  logic [ADDR_W-1:0]     wr_addr_q;
  logic [ADDR_W-1:0]     wr_addr_d;
  logic [DATA_W-1:0]     rdata_q;
  logic [DATA_W-1:0]     rdata_d;
  logic                  ready_q;
  logic                  access;

  // Register state
  logic [15:0]           mode_q;
  logic [15:0]           mode_d;
  logic [RMS_W-1:0]      nom_q;
  logic [RMS_W-1:0]      nom_d;
  logic [DATA_W-1:0]     cnt_q;
  logic [DATA_W-1:0]     cnt_d;

  // Datapath state
  logic                  stage_q;
  logic                  stage_d;
  logic                  valid_q;
  logic                  valid_d;
  logic                  ang_vi_q;
  logic                  ang_vv_q;
  logic                  ang_ii_q;
  logic                  ang_vi_d;
  logic                  ang_vv_d;
  logic                  ang_ii_d;
  logic [2:0]            ignore_q;
  logic [2:0]            ignore_d;
  angle_mode_e           angle_mode;

  // Submodule results
  logic signed [POWER_W+1:0] sum_one;
  logic signed [POWER_W+1:0] sum_two;
  logic signed [POWER_W+1:0] sum_three;
  logic [RMS_W-1:0]          veff_a;
  logic [RMS_W-1:0]          veff_b;
  logic [RMS_W-1:0]          veff_c;
  logic [2*RMS_W-1:0]        app_a;
  logic [2*RMS_W-1:0]        app_b;
  logic [2*RMS_W-1:0]        app_c;

  // Output registers
  logic signed [POWER_W+1:0] out_one_q;
  logic signed [POWER_W+1:0] out_two_q;
  logic signed [POWER_W+1:0] out_three_q;
  logic [RMS_W-1:0]          out_veff_a_q;
  logic [RMS_W-1:0]          out_veff_b_q;
  logic [RMS_W-1:0]          out_veff_c_q;
  logic [2*RMS_W-1:0]        out_app_a_q;
  logic [2*RMS_W-1:0]        out_app_b_q;
  logic [2*RMS_W-1:0]        out_app_c_q;

  assign access     = HSEL && (HTRANS == HTRANS_NONSEQ) && HREADY;
  assign angle_mode = angle_mode_e'(mode_q[F_ANGLE_LSB +: 2]);

  // Register writes commit in the data phase
  always_comb begin
    mode_d    = mode_q;
    nom_d     = nom_q;
    wr_pend_d = access && HWRITE;
    wr_addr_d = access ? HADDR : wr_addr_q;
    if (wr_pend_q) begin
      if (addr_is(wr_addr_q, ADDR_COMP_MODE)) begin
        mode_d = HWDATA[15:0] & COMP_MODE_MASK;
      end else if (addr_is(wr_addr_q, ADDR_NOM_VOLTAGE)) begin
        nom_d = HWDATA[RMS_W-1:0];
      end
    end
  end

  // Read data uses next values so a read right after a write sees it
  always_comb begin
    rdata_d = '0;
    if (access && !HWRITE) begin
      if (addr_is(HADDR, ADDR_COMP_MODE)) begin
        rdata_d = {16'h0000, mode_d};
      end else if (addr_is(HADDR, ADDR_NOM_VOLTAGE)) begin
        rdata_d = DATA_W'(nom_d);
      end else if (addr_is(HADDR, ADDR_STATUS)) begin
        rdata_d = DATA_W'({angle_mode, 1'b0, ignore_q});
      end else if (addr_is(HADDR, ADDR_RESULT_CNT)) begin
        rdata_d = cnt_q;
      end else begin
        rdata_d = '0;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rdata_q   <= '0;
      ready_q   <= 1'b0;
      mode_q    <= COMP_MODE_RESET;
      nom_q     <= NOM_VOLT_RESET;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
      ready_q   <= 1'b1;
      mode_q    <= mode_d;
      nom_q     <= nom_d;
    end
  end

  // Angle decode; the field is stored as written and read back unchanged
  always_comb begin
    ang_vi_d = 1'b0;
    ang_vv_d = 1'b0;
    ang_ii_d = 1'b0;
    case (angle_mode)
      ANG_V_TO_I: ang_vi_d = 1'b1;
      ANG_V_TO_V: ang_vv_d = 1'b1;
      ANG_I_TO_I: ang_ii_d = 1'b1;
      ANG_NONE:   ang_vi_d = 1'b0;
      default:    ang_vi_d = 1'b0;
    endcase
  end

  // Voltage inputs dropped for phases running on the nominal value
  always_comb begin
    ignore_d    = ignore_q;
    ignore_d[0] = mode_q[F_NOM_A];
    ignore_d[1] = mode_q[F_NOM_B];
    ignore_d[2] = mode_q[F_NOM_C];
  end

  // Two-stage result timing and a count of completed results
  always_comb begin
    stage_d = SAMPLE_VALID;
    valid_d = stage_q;
    cnt_d   = stage_q ? cnt_q + 32'h00000001 : cnt_q;
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ang_vi_q <= 1'b1;
      ang_vv_q <= 1'b0;
      ang_ii_q <= 1'b0;
      ignore_q <= '0;
      stage_q  <= 1'b0;
      valid_q  <= 1'b0;
      cnt_q    <= '0;
    end else begin
      ang_vi_q <= ang_vi_d;
      ang_vv_q <= ang_vv_d;
      ang_ii_q <= ang_ii_d;
      ignore_q <= ignore_d;
      stage_q  <= stage_d;
      valid_q  <= valid_d;
      cnt_q    <= cnt_d;
    end
  end

  // Phase selection per pulse output; config sampled at each sample
  phase_term_sum #(.W(POWER_W)) u_sum_one (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .sel   (mode_q[F_SEL_ONE_LSB +: 3]),
    .valid (SAMPLE_VALID),
    .val_a (POWER_A),
    .val_b (POWER_B),
    .val_c (POWER_C),
    .sum   (sum_one)
  );

  phase_term_sum #(.W(POWER_W)) u_sum_two (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .sel   (mode_q[F_SEL_TWO_LSB +: 3]),
    .valid (SAMPLE_VALID),
    .val_a (POWER_A),
    .val_b (POWER_B),
    .val_c (POWER_C),
    .sum   (sum_two)
  );

  phase_term_sum #(.W(POWER_W)) u_sum_three (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .sel   (mode_q[F_SEL_THREE_LSB +: 3]),
    .valid (SAMPLE_VALID),
    .val_a (POWER_A),
    .val_b (POWER_B),
    .val_c (POWER_C),
    .sum   (sum_three)
  );

  // Apparent power per phase with optional nominal voltage
  apparent_calc #(.VW(RMS_W), .IW(RMS_W)) u_app_a (
    .clk       (MCLK),
    .rst_n     (RESET_N),
    .nom_en    (mode_q[F_NOM_A]),
    .nom_value (nom_q),
    .valid     (SAMPLE_VALID),
    .vrms      (VRMS_A),
    .irms      (IRMS_A),
    .veff      (veff_a),
    .apparent  (app_a)
  );

  apparent_calc #(.VW(RMS_W), .IW(RMS_W)) u_app_b (
    .clk       (MCLK),
    .rst_n     (RESET_N),
    .nom_en    (mode_q[F_NOM_B]),
    .nom_value (nom_q),
    .valid     (SAMPLE_VALID),
    .vrms      (VRMS_B),
    .irms      (IRMS_B),
    .veff      (veff_b),
    .apparent  (app_b)
  );

  apparent_calc #(.VW(RMS_W), .IW(RMS_W)) u_app_c (
    .clk       (MCLK),
    .rst_n     (RESET_N),
    .nom_en    (mode_q[F_NOM_C]),
    .nom_value (nom_q),
    .valid     (SAMPLE_VALID),
    .vrms      (VRMS_C),
    .irms      (IRMS_C),
    .veff      (veff_c),
    .apparent  (app_c)
  );

  // Second register stage keeps the sum, effective voltage and apparent power outputs on local flops
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_one_q    <= '0;
      out_two_q    <= '0;
      out_three_q  <= '0;
      out_veff_a_q <= '0;
      out_veff_b_q <= '0;
      out_veff_c_q <= '0;
      out_app_a_q  <= '0;
      out_app_b_q  <= '0;
      out_app_c_q  <= '0;
    end else begin
      out_one_q    <= sum_one;
      out_two_q    <= sum_two;
      out_three_q  <= sum_three;
      out_veff_a_q <= veff_a;
      out_veff_b_q <= veff_b;
      out_veff_c_q <= veff_c;
      out_app_a_q  <= app_a;
      out_app_b_q  <= app_b;
      out_app_c_q  <= app_c;
    end
  end

  assign HRDATA               = rdata_q;
  assign HREADYOUT            = ready_q;
  assign HRESP                = HRESP_OKAY;
  assign PULSE_OUT_ONE_SUM    = out_one_q;
  assign PULSE_OUT_TWO_SUM    = out_two_q;
  assign PULSE_OUT_THREE_SUM  = out_three_q;
  assign VRMS_EFF_A           = out_veff_a_q;
  assign VRMS_EFF_B           = out_veff_b_q;
  assign VRMS_EFF_C           = out_veff_c_q;
  assign APPARENT_A           = out_app_a_q;
  assign APPARENT_B           = out_app_b_q;
  assign APPARENT_C           = out_app_c_q;
  assign RESULT_VALID         = valid_q;
  assign ANGLE_V_TO_I_EN      = ang_vi_q;
  assign ANGLE_V_TO_V_EN      = ang_vv_q;
  assign ANGLE_I_TO_I_EN      = ang_ii_q;
  assign VOLTAGE_INPUT_IGNORE = ignore_q;

endmodule : metering_compute_mode_config
`default_nettype wire

// File: verif/cfg_mode_sva.sv
// Port assertions for the computation mode configuration block
`timescale 1ns/1ps
`default_nettype none
module cfg_mode_sva
  import metering_cfg_pkg::*;
#(
  parameter int unsigned RMS_W = 24
) (
  // Clock and reset
  input wire logic               MCLK,
  input wire logic               RESET_N,
  // Bus answer
  input wire logic               HREADYOUT,
  input wire logic               HRESP,
  // Measurements
  input wire logic               SAMPLE_VALID,
  input wire logic [RMS_W-1:0]   VRMS_A,
  input wire logic [RMS_W-1:0]   VRMS_C,
  input wire logic [RMS_W-1:0]   IRMS_A,
  input wire logic [RMS_W-1:0]   IRMS_B,
  input wire logic [RMS_W-1:0]   IRMS_C,
  // Results
  input wire logic               RESULT_VALID,
  input wire logic [RMS_W-1:0]   VRMS_EFF_A,
  input wire logic [RMS_W-1:0]   VRMS_EFF_B,
  input wire logic [RMS_W-1:0]   VRMS_EFF_C,
  input wire logic [2*RMS_W-1:0] APPARENT_A,
  input wire logic [2*RMS_W-1:0] APPARENT_B,
  input wire logic [2*RMS_W-1:0] APPARENT_C,
  // Angle and voltage control
  input wire logic               ANGLE_V_TO_I_EN,
  input wire logic               ANGLE_V_TO_V_EN,
  input wire logic               ANGLE_I_TO_I_EN,
  input wire logic [2:0]         VOLTAGE_INPUT_IGNORE
);
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // Result lands two edges after the sample is taken
  sequence s_result;
    ##2 RESULT_VALID;
  endsequence

  AST_RESULT_LATENCY: assert property (SAMPLE_VALID |-> s_result)
    else $error("result pulse missing two cycles after sample");
  AST_RESULT_CAUSE: assert property (RESULT_VALID |-> $past(SAMPLE_VALID, 2))
    else $error("result pulse without a sample");
  AST_VEFF_A_MEAS: assert property (RESULT_VALID && !VOLTAGE_INPUT_IGNORE[0] |->
    VRMS_EFF_A == $past(VRMS_A, 2)) else $error("phase A measured voltage not used");
  AST_VEFF_C_MEAS: assert property (RESULT_VALID && !VOLTAGE_INPUT_IGNORE[2] |->
    VRMS_EFF_C == $past(VRMS_C, 2)) else $error("phase C measured voltage not used");
  AST_NOM_AB_EQUAL: assert property (RESULT_VALID && VOLTAGE_INPUT_IGNORE[1:0] == 2'b11
    |-> VRMS_EFF_A == VRMS_EFF_B) else $error("nominal voltage differs on A and B");
  AST_APP_A: assert property (RESULT_VALID |->
    APPARENT_A == VRMS_EFF_A * $past(IRMS_A, 2)) else $error("phase A apparent power wrong");
  AST_APP_B: assert property (RESULT_VALID |->
    APPARENT_B == VRMS_EFF_B * $past(IRMS_B, 2)) else $error("phase B apparent power wrong");
  AST_APP_C: assert property (RESULT_VALID |->
    APPARENT_C == VRMS_EFF_C * $past(IRMS_C, 2)) else $error("phase C apparent power wrong");
  AST_ANGLE_ONEHOT: assert property (
    $onehot0({ANGLE_V_TO_I_EN, ANGLE_V_TO_V_EN, ANGLE_I_TO_I_EN}))
    else $error("more than one angle mode enabled");
  AST_RESULT_HOLD: assert property (!RESULT_VALID |->
    $stable(APPARENT_A) && $stable(VRMS_EFF_B)) else $error("results moved between pulses");
  AST_BUS_READY: assert property ($past(RESET_N) |-> HREADYOUT && HRESP == HRESP_OKAY)
    else $error("bus not ready or not okay");
endmodule : cfg_mode_sva
`default_nettype wire

// File: verif/metering_compute_mode_config_tb.sv
// Self-checking bench for the computation mode configuration block
`timescale 1ns/1ps
`default_nettype none
module metering_compute_mode_config_tb;
  import metering_cfg_pkg::*;
  logic               clk;
  logic               rst_n;
  logic               hsel;
  logic [ADDR_W-1:0]  haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [DATA_W-1:0]  hwdata;
  wire  [DATA_W-1:0]  hrdata;
  wire                hreadyout;
  wire                hresp;
  logic               sample_valid;
  logic signed [23:0] pa, pb, pc;
  logic [23:0]        vra, vrb, vrc, ira, irb, irc;
  wire signed [25:0]  sum1, sum2, sum3;
  wire [23:0]         ea, eb, ec;
  wire [47:0]         sa, sb, sc;
  wire                result_valid;
  wire                a_vi, a_vv, a_ii;
  wire [2:0]          ign;
  logic               rdy_q;
  logic [DATA_W-1:0]  rdat_q;
  int                 mismatches;
  int                 total_checks;

  metering_compute_mode_config u_metering_compute_mode_config (
    .MCLK(clk), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SAMPLE_VALID(sample_valid),
    .POWER_A(pa), .POWER_B(pb), .POWER_C(pc), .VRMS_A(vra), .VRMS_B(vrb), .VRMS_C(vrc),
    .IRMS_A(ira), .IRMS_B(irb), .IRMS_C(irc), .PULSE_OUT_ONE_SUM(sum1),
    .PULSE_OUT_TWO_SUM(sum2), .PULSE_OUT_THREE_SUM(sum3), .VRMS_EFF_A(ea),
    .VRMS_EFF_B(eb), .VRMS_EFF_C(ec), .APPARENT_A(sa), .APPARENT_B(sb), .APPARENT_C(sc),
    .RESULT_VALID(result_valid), .ANGLE_V_TO_I_EN(a_vi), .ANGLE_V_TO_V_EN(a_vv),
    .ANGLE_I_TO_I_EN(a_ii), .VOLTAGE_INPUT_IGNORE(ign)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Settled values just before each rising edge
  always @(negedge clk) begin
    rdy_q = hreadyout;
    rdat_q = hrdata;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One single AHB transfer; waits on ready, never on a fixed latency
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    n = 0;
    do begin @(posedge clk); n++; end while (rdy_q !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (rdy_q !== 1'b1 && n < 100);
    rd = rdat_q;
    if (n >= 100) begin mismatches++; close_out(); end
  endtask : bus

  task automatic sample();
    int n;
    @(posedge clk);
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (result_valid !== 1'b1 && n < 10);
    if (n >= 10) begin mismatches++; close_out(); end
  endtask : sample

  function automatic logic signed [25:0] esum(input logic [2:0] s);
    return (s[0] ? 26'(pa) : 26'sd0) + (s[1] ? 26'(pb) : 26'sd0) + (s[2] ? 26'(pc) : 26'sd0);
  endfunction : esum

  task automatic t_reset();
    logic [31:0] rd;
    chk("angle_out", 3'b100, {a_vi, a_vv, a_ii});
    chk("ignore_out", 3'b000, ign);
    bus(1'b0, ADDR_COMP_MODE, 32'h0, rd);
    chk("cfg_reset", 32'h000001ff, rd);
    bus(1'b0, ADDR_NOM_VOLTAGE, 32'h0, rd);
    chk("nom_reset", 32'h0, rd);
    bus(1'b1, ADDR_COMP_MODE, 32'h0000ffff, rd);
    bus(1'b0, ADDR_COMP_MODE, 32'h0, rd);
    chk("cfg_unused_bits", 32'h00003fff, rd);
    bus(1'b1, 20'h00010, 32'hffffffff, rd);
    bus(1'b0, 20'h00010, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("hresp", HRESP_OKAY, hresp);
  endtask : t_reset

  task automatic t_sums();
    logic [31:0] rd;
    logic [2:0]  s1, s2, s3;
    // Table walks every code of each select, all-ones included
    for (int i = 0; i < 8; i++) begin
      s1 = 3'(i);
      s2 = s1 ^ 3'h5;
      s3 = ~s1;
      bus(1'b1, ADDR_COMP_MODE, {23'h0, s3, s2, s1}, rd);
      bus(1'b0, ADDR_COMP_MODE, 32'h0, rd);
      chk("cfg_readback", {23'h0, s3, s2, s1}, rd);
      sample();
      chk("sum_one", esum(s1), sum1);
      chk("sum_two", esum(s2), sum2);
      chk("sum_three", esum(s3), sum3);
    end
    // One result per sample taken above
    bus(1'b0, ADDR_RESULT_CNT, 32'h0, rd);
    chk("result_count", 32'd8, rd);
  endtask : t_sums

  task automatic t_angle();
    logic [31:0] rd;
    for (int a = 0; a < 4; a++) begin
      bus(1'b1, ADDR_COMP_MODE, {21'h0, 2'(a), 9'h1ff}, rd);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("angle_out", 3'b100 >> a, {a_vi, a_vv, a_ii});
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      chk("status_angle", 32'(a) << S_ANGLE_LSB, rd);
    end
  endtask : t_angle

  task automatic t_nominal();
    logic [31:0] rd;
    logic [23:0] xa, xb, xc;
    logic [2:0]  m;
    bus(1'b1, ADDR_NOM_VOLTAGE, 32'h00123456, rd);
    bus(1'b0, ADDR_NOM_VOLTAGE, 32'h0, rd);
    chk("nom_readback", 32'h00123456, rd);
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      bus(1'b1, ADDR_COMP_MODE, {18'h0, m, 11'h1ff}, rd);
      sample();
      xa = m[0] ? 24'h123456 : vra;
      xb = m[1] ? 24'h123456 : vrb;
      xc = m[2] ? 24'h123456 : vrc;
      chk("ignore_out", m, ign);
      chk("veff_a", xa, ea);
      chk("veff_b", xb, eb);
      chk("veff_c", xc, ec);
      chk("app_a", xa * ira, sa);
      chk("app_b", xb * irb, sb);
      chk("app_c", xc * irc, sc);
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      chk("status_ignore", 32'(m), rd);
    end
  endtask : t_nominal

  initial begin
    mismatches = 0;
    total_checks = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    sample_valid = 1'b0;
    pa = 24'sd1000;
    pb = -24'sd20000;
    pc = 24'sd300000;
    vra = 24'h0a0000;
    vrb = 24'h0b0000;
    vrc = 24'h0c0000;
    ira = 24'h000100;
    irb = 24'h000200;
    irc = 24'h000300;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    t_reset();
    t_sums();
    t_angle();
    t_nominal();
    close_out();
  end
endmodule : metering_compute_mode_config_tb

bind metering_compute_mode_config cfg_mode_sva #(.RMS_W(RMS_W)) u_cfg_mode_sva (
  .MCLK, .RESET_N, .HREADYOUT, .HRESP, .SAMPLE_VALID, .VRMS_A, .VRMS_C, .IRMS_A,
  .IRMS_B, .IRMS_C, .RESULT_VALID, .VRMS_EFF_A, .VRMS_EFF_B, .VRMS_EFF_C, .APPARENT_A,
  .APPARENT_B, .APPARENT_C, .ANGLE_V_TO_I_EN, .ANGLE_V_TO_V_EN, .ANGLE_I_TO_I_EN,
  .VOLTAGE_INPUT_IGNORE
);
`default_nettype wire
